// ---- rtl/aan_annunciator.v ----
// anomaly annunciator: horn, acknowledge, reset, cumulatives, override, input anomalies
// assumes synchronous inputs, one clock, register writes as address/data/strobe
`timescale 1ns/100ps
`include "aan_consts.vh"

// Function
// RULE_01: panel button while horn sounds only silences the horn.
// RULE_02: rising edge of acknowledge input silences the horn.
// RULE_03: master writes password to 101 then command to 102 within five seconds.
// RULE_04: command 51 silences, 52 acknowledges, 53 resets.
// RULE_05: remote acknowledge also silences an active horn.
// RULE_06: duration zero never sounds; 999 sounds until silenced.
// RULE_07: duration 1..998 sounds until silenced or time expires.
// RULE_08: with horn on, first press silences, second press acknowledges.
// RULE_09: rising edge of acknowledge input acknowledges pending anomalies.
// RULE_10: acknowledged warning clears automatically once cause is gone.
// RULE_11: anomaly whose cause vanishes unacknowledged stays latched.
// RULE_12: no anomaly is cancelled while its cause persists.
// RULE_13: unloads and alarms clear only by key, reset input edge or remote reset.
// RULE_14: reset sequence drives reset pulse output for one second.
// RULE_15: external horn follows internal horn exactly.
// RULE_16: acknowledge sequence drives acknowledge pulse output for one second.
// RULE_17: cumulative outputs for warning, unload, alarm, alarm-or-unload.
// RULE_18: breaker output active while any breaker anomaly is active.
// RULE_19: status flags for pulses, cumulatives and unacknowledged cumulatives.
// RULE_20: override input downgrades override-subject alarms and unloads to warnings.
// RULE_21: log an event when override starts and another when it ends.
// RULE_22: generic input anomaly activates after its delay; zero delay disables.
// RULE_23: alarm needs no alarm active; unload or warning needs none of either.
// RULE_24: command without valid password in preceding five seconds is ignored; the code accepts it while the password bypass input is high.
// RULE_25: activation sets horn request, unacknowledged flag and logs the code.
module aan_annunciator (
  input  wire                            i_clk,
  input  wire                            i_sys_rst,
  input  wire                            i_ce,
  input  wire [`AAN_N_ANOM-1:0]          i_cause,
  input  wire [2*`AAN_N_ANOM-1:0]        i_category,
  input  wire [`AAN_N_ANOM-1:0]          i_override_subject,
  input  wire [`AAN_N_GEN-1:0]           i_gen_input,
  input  wire [16*`AAN_N_GEN-1:0]        i_gen_delay_ms,
  input  wire [2*`AAN_N_GEN-1:0]         i_gen_category,
  input  wire [`AAN_N_GEN-1:0]           i_gen_override_subject,
  input  wire [9:0]                      i_horn_duration_s,
  input  wire                            i_ack_button,
  input  wire                            i_ack_command_input_fn,
  input  wire                            i_fault_reset_input_fn,
  input  wire                            i_key_off_reset,
  input  wire                            i_password_bypass_input_fn,
  input  wire                            i_protection_bypass_input_fn,
  input  wire [15:0]                     i_password_cfg,
  input  wire                            i_reg_wr,
  input  wire [15:0]                     i_reg_addr,
  input  wire [15:0]                     i_reg_wdata,
  output reg                             o_horn,
  output wire                            o_external_horn_output,
  output reg                             o_ack_pulse_output,
  output reg                             o_reset_pulse_output,
  output wire                            o_ack_pulse_status,
  output wire                            o_reset_pulse_status,
  output reg                             o_any_warning_output,
  output reg                             o_any_unload_output,
  output reg                             o_any_alarm_output,
  output reg                             o_any_alarm_or_unload_output,
  output reg                             o_breaker_fault_output,
  output reg                             o_unacked_warning_status,
  output reg                             o_unacked_unload_status,
  output reg                             o_unacked_alarm_status,
  output reg  [`AAN_N_ANOM+`AAN_N_GEN-1:0] o_active,
  output reg  [`AAN_N_ANOM+`AAN_N_GEN-1:0] o_flashing,
  output reg                             o_event_valid,
  output reg  [`AAN_CODE_W-1:0]          o_event_code,
  output reg                             o_bypass_start_event,
  output reg                             o_bypass_end_event
);

  localparam N        = `AAN_N_ANOM + `AAN_N_GEN;
  localparam [31:0] SEC_CYC = `AAN_CYC_PER_SEC;
  localparam [31:0] PW_CYC  = `AAN_CYC_PER_SEC * `AAN_PW_WINDOW_S;
  localparam [31:0] MS_CYC  = `AAN_CYC_PER_SEC / 1000;
  localparam [`AAN_CODE_W-1:0] N_ANOM_C = `AAN_N_ANOM;

  // edge detection of operator inputs
  reg                 ack_btn_q;
  reg                 ack_in_q;
  reg                 rst_in_q;
  reg                 bypass_q;
  wire                btn_rise  = i_ack_button & ~ack_btn_q;
  wire                ack_rise  = i_ack_command_input_fn & ~ack_in_q;
  wire                rst_rise  = i_fault_reset_input_fn & ~rst_in_q;

  // password window and remote command decode
  reg                 pw_ok;
  reg  [31:0]         pw_cnt;
  wire                wr_pw     = i_reg_wr & (i_reg_addr == `AAN_REG_PASSWORD);
  wire                wr_cmd    = i_reg_wr & (i_reg_addr == `AAN_REG_COMMAND);
  wire                cmd_ok    = wr_cmd & (pw_ok | i_password_bypass_input_fn); // RULE_24
  wire                rem_sil   = cmd_ok & (i_reg_wdata == `AAN_CMD_SILENCE);   // RULE_04
  wire                rem_ack   = cmd_ok & (i_reg_wdata == `AAN_CMD_ACK);       // RULE_04
  wire                rem_rst   = cmd_ok & (i_reg_wdata == `AAN_CMD_RESET);     // RULE_04

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      pw_ok  <= 1'b0;
      pw_cnt <= 32'h0000_0000;
    end else if (i_ce) begin
      if (wr_pw) begin
        pw_ok  <= (i_reg_wdata == i_password_cfg); // RULE_03
        pw_cnt <= PW_CYC;
      end else if (wr_cmd) begin
        pw_ok  <= 1'b0;
      end else if (pw_ok) begin
        if (pw_cnt <= 32'h0000_0001)
          pw_ok <= 1'b0; // RULE_24
        pw_cnt <= pw_cnt - 32'h0000_0001;
      end
    end
  end

  // horn silencing, acknowledge and reset sources
  wire                silence   = (btn_rise & o_horn) | ack_rise | rem_sil | (rem_ack & o_horn); // RULE_01 RULE_02 RULE_05
  wire                do_ack    = (btn_rise & ~o_horn) | ack_rise | rem_ack; // RULE_08 RULE_09
  wire                do_reset  = i_key_off_reset | rst_rise | rem_rst; // RULE_13

  // generic input anomaly qualification
  reg  [N-1:0]        cause_all;
  reg  [2*N-1:0]      cat_raw;
  reg  [N-1:0]        ovr_all;
  wire [`AAN_N_GEN-1:0] gen_hit;

  genvar g;
  generate
    for (g = 0; g < `AAN_N_GEN; g = g + 1) begin : gen_q
      reg  [31:0] cnt;
      reg         hit;
      wire [15:0] dly = i_gen_delay_ms[16*g +: 16];
      always @(posedge i_clk) begin
        if (i_sys_rst) begin
          cnt <= 32'h0000_0000;
          hit <= 1'b0;
        end else if (i_ce) begin
          if (!i_gen_input[g] || dly == 16'h0000) begin
            cnt <= 32'h0000_0000;
            hit <= 1'b0; // RULE_22
          end else if (cnt >= dly * MS_CYC) begin
            hit <= 1'b1; // RULE_22
          end else begin
            cnt <= cnt + 32'h0000_0001;
          end
        end
      end
      assign gen_hit[g] = hit;
    end
  endgenerate

  always @* begin
    cause_all = {gen_hit, i_cause};
    cat_raw   = {i_gen_category, i_category};
    ovr_all   = {i_gen_override_subject, i_override_subject};
  end

  // per-anomaly latch state
  reg  [N-1:0]        unacked;
  reg  [N-1:0]        is_warn;
  reg  [N-1:0]        is_unl;
  reg  [N-1:0]        is_alm;
  reg  [N-1:0]        new_act;
  reg  [N-1:0]        next_active;
  reg  [N-1:0]        cause_q;
  integer             k;

  always @* begin
    for (k = 0; k < N; k = k + 1) begin
      is_alm[k]  = (cat_raw[2*k +: 2] == `AAN_CAT_ALARM) &
                   ~(i_protection_bypass_input_fn & ovr_all[k]); // RULE_20
      is_unl[k]  = (cat_raw[2*k +: 2] == `AAN_CAT_UNLOAD) &
                   ~(i_protection_bypass_input_fn & ovr_all[k]); // RULE_20
      is_warn[k] = ~is_alm[k] & ~is_unl[k];
    end
  end

  always @* begin
    new_act = {N{1'b0}};
    for (k = 0; k < N; k = k + 1) begin
      if (cause_all[k] & ~cause_q[k] & ~o_active[k]) begin
        if (is_alm[k])
          new_act[k] = ~o_any_alarm_output; // RULE_23
        else
          new_act[k] = ~o_any_alarm_or_unload_output; // RULE_23
      end
    end
    next_active = o_active;
    for (k = 0; k < N; k = k + 1) begin
      if (new_act[k])
        next_active[k] = 1'b1; // RULE_25
      else if (o_active[k] && !cause_all[k] && !unacked[k]) begin // RULE_11 RULE_12
        if (is_warn[k] || do_reset)
          next_active[k] = 1'b0; // RULE_10 RULE_13
      end
    end
  end

  // first new activation for the event log
  reg  [`AAN_CODE_W-1:0] new_code;
  reg                    new_any;
  always @* begin
    new_code = {`AAN_CODE_W{1'b0}};
    new_any  = 1'b0;
    for (k = N - 1; k >= 0; k = k - 1) begin
      if (new_act[k]) begin
        new_any  = 1'b1;
        new_code = (k < `AAN_N_ANOM) ? k[`AAN_CODE_W-1:0] + 10'h001
                 : `AAN_GEN_CODE_BASE + k[`AAN_CODE_W-1:0] - N_ANOM_C;
      end
    end
  end

  // horn timing
  reg  [31:0]         sec_cnt;
  reg  [9:0]          horn_s;

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      ack_btn_q      <= 1'b0;
      ack_in_q       <= 1'b0;
      rst_in_q       <= 1'b0;
      bypass_q       <= 1'b0;
      cause_q        <= {N{1'b0}};
      o_active       <= {N{1'b0}};
      unacked        <= {N{1'b0}};
      o_horn         <= 1'b0;
      sec_cnt        <= 32'h0000_0000;
      horn_s         <= 10'h000;
      o_event_valid  <= 1'b0;
      o_event_code   <= {`AAN_CODE_W{1'b0}};
      o_bypass_start_event <= 1'b0;
      o_bypass_end_event   <= 1'b0;
    end else if (i_ce) begin
      ack_btn_q <= i_ack_button;
      ack_in_q  <= i_ack_command_input_fn;
      rst_in_q  <= i_fault_reset_input_fn;
      bypass_q  <= i_protection_bypass_input_fn;
      cause_q   <= cause_all;
      o_active  <= next_active;
      unacked   <= (do_ack ? {N{1'b0}} : unacked) | new_act; // RULE_25 RULE_09
      o_event_valid <= new_any; // RULE_25
      if (new_any)
        o_event_code <= new_code;
      o_bypass_start_event <= i_protection_bypass_input_fn & ~bypass_q; // RULE_21
      o_bypass_end_event   <= ~i_protection_bypass_input_fn & bypass_q; // RULE_21
      if (new_any && i_horn_duration_s != `AAN_HORN_OFF) begin
        o_horn  <= 1'b1; // RULE_06 RULE_07
        sec_cnt <= 32'h0000_0000;
        horn_s  <= 10'h000;
      end else if (silence || i_horn_duration_s == `AAN_HORN_OFF) begin
        o_horn <= 1'b0; // RULE_06
      end else if (o_horn && i_horn_duration_s != `AAN_HORN_FOREVER) begin
        if (sec_cnt >= SEC_CYC - 32'h0000_0001) begin
          sec_cnt <= 32'h0000_0000;
          horn_s  <= horn_s + 10'h001;
          if (horn_s + 10'h001 >= i_horn_duration_s)
            o_horn <= 1'b0; // RULE_07
        end else begin
          sec_cnt <= sec_cnt + 32'h0000_0001;
        end
      end
    end
  end

  assign o_external_horn_output = o_horn; // RULE_15

  // one-second acknowledge and reset pulses
  reg  [31:0]         ack_cnt;
  reg  [31:0]         rst_cnt;
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      ack_cnt              <= 32'h0000_0000;
      rst_cnt              <= 32'h0000_0000;
      o_ack_pulse_output   <= 1'b0;
      o_reset_pulse_output <= 1'b0;
    end else if (i_ce) begin
      if (do_ack) begin
        ack_cnt            <= SEC_CYC - 32'h0000_0001;
        o_ack_pulse_output <= 1'b1; // RULE_16
      end else if (ack_cnt != 32'h0000_0000) begin
        ack_cnt <= ack_cnt - 32'h0000_0001;
      end else begin
        o_ack_pulse_output <= 1'b0;
      end
      if (do_reset) begin
        rst_cnt              <= SEC_CYC - 32'h0000_0001;
        o_reset_pulse_output <= 1'b1; // RULE_14
      end else if (rst_cnt != 32'h0000_0000) begin
        rst_cnt <= rst_cnt - 32'h0000_0001;
      end else begin
        o_reset_pulse_output <= 1'b0;
      end
    end
  end

  assign o_ack_pulse_status   = o_ack_pulse_output;   // RULE_19
  assign o_reset_pulse_status = o_reset_pulse_output; // RULE_19

  // cumulative outputs
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_any_warning_output         <= 1'b0;
      o_any_unload_output          <= 1'b0;
      o_any_alarm_output           <= 1'b0;
      o_any_alarm_or_unload_output <= 1'b0;
      o_breaker_fault_output       <= 1'b0;
      o_unacked_warning_status     <= 1'b0;
      o_unacked_unload_status      <= 1'b0;
      o_unacked_alarm_status       <= 1'b0;
      o_flashing                   <= {N{1'b0}};
    end else if (i_ce) begin
      o_any_warning_output         <= |(next_active & is_warn); // RULE_17 RULE_19
      o_any_unload_output          <= |(next_active & is_unl);  // RULE_17 RULE_19
      o_any_alarm_output           <= |(next_active & is_alm);  // RULE_17 RULE_19
      o_any_alarm_or_unload_output <= |(next_active & (is_alm | is_unl)); // RULE_17
      o_breaker_fault_output       <= |(next_active[`AAN_N_ANOM-1:0] & `AAN_BREAKER_MASK); // RULE_18
      o_unacked_warning_status     <= |(o_active & unacked & is_warn); // RULE_19
      o_unacked_unload_status      <= |(o_active & unacked & is_unl);  // RULE_19
      o_unacked_alarm_status       <= |(o_active & unacked & is_alm);  // RULE_19
      o_flashing                   <= o_active & unacked;
    end
  end

endmodule

// ---- rtl/aan_consts.vh ----
// constants for the anomaly annunciator: register offsets, command codes, timing
// assumes a 100 MHz system clock
`ifndef AAN_CONSTS_VH
`define AAN_CONSTS_VH
`define AAN_REG_PASSWORD     16'h0065
`define AAN_REG_COMMAND      16'h0066
`define AAN_CMD_SILENCE      16'h0033
`define AAN_CMD_ACK          16'h0034
`define AAN_CMD_RESET        16'h0035
`define AAN_HORN_OFF         10'h000
`define AAN_HORN_FOREVER     10'h3E7
`define AAN_CLK_HZ           100000000
`define AAN_ONE_SECOND_S     1
`define AAN_CYC_PER_SEC      (`AAN_CLK_HZ * `AAN_ONE_SECOND_S)
`define AAN_PW_WINDOW_S      5
`define AAN_N_ANOM           8
`define AAN_N_GEN            4
`define AAN_CAT_WARN         2'h0
`define AAN_CAT_UNLOAD       2'h1
`define AAN_CAT_ALARM        2'h2
`define AAN_BREAKER_MASK     8'h0F
`define AAN_CODE_W           10
`define AAN_GEN_CODE_BASE    10'h2BD
`endif

// ---- verif/aan_master.sv ----
// modbus master model: password and command holding-register writes
// assumes i_ce held high, strobe sampled on rising i_clk
`timescale 1ns/100ps
`include "aan_consts.vh"
module aan_master (
  input  wire        i_clk,
  output reg         o_wr,
  output reg  [15:0] o_addr,
  output reg  [15:0] o_wdata
);
  initial begin
    o_wr = 1'b0;
    o_addr = 16'h0000;
    o_wdata = 16'h0000;
  end
  // one-cycle strobe; released lines show the inverse of the last value
  task wr(input [15:0] a, input [15:0] d);
    begin
      @(negedge i_clk);
      o_wr = 1'b1;
      o_addr = a;
      o_wdata = d;
      @(negedge i_clk);
      o_wr = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
    end
  endtask
  // password then command, far inside the five second window
  task cmd(input [15:0] pw, input [15:0] code);
    begin
      wr(`AAN_REG_PASSWORD, pw);
      wr(`AAN_REG_COMMAND, code);
    end
  endtask
endmodule

// ---- verif/aan_annunciator_props.sv ----
// port checker for the anomaly annunciator
// assumes one clock and the bind at the foot of this file
`timescale 1ns/100ps
`include "aan_consts.vh"
module aan_annunciator_props (
  input wire        i_clk,
  input wire        i_sys_rst,
  input wire        i_ce,
  input wire [7:0]  i_cause,
  input wire [3:0]  i_gen_input,
  input wire [9:0]  i_horn_duration_s,
  input wire        i_ack_command_input_fn,
  input wire        i_fault_reset_input_fn,
  input wire        i_key_off_reset,
  input wire        i_password_bypass_input_fn,
  input wire        i_reg_wr,
  input wire [15:0] i_reg_addr,
  input wire [15:0] i_reg_wdata,
  input wire        o_horn,
  input wire        o_external_horn_output,
  input wire        o_ack_pulse_output,
  input wire        o_reset_pulse_output,
  input wire        o_reset_pulse_status,
  input wire        o_breaker_fault_output,
  input wire        o_any_warning_output,
  input wire [11:0] o_active
);
  reg       pw_any;
  reg [7:0] held;
  // password seen since the last command write
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      pw_any <= 1'b0;
      held <= 8'h00;
    end else begin
      held <= o_active[7:0] & i_cause;
      if (i_ce && i_reg_wr && i_reg_addr == `AAN_REG_PASSWORD)
        pw_any <= 1'b1;
      else if (i_ce && i_reg_wr && i_reg_addr == `AAN_REG_COMMAND)
        pw_any <= 1'b0;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  AST_EXT_HORN: assert property (o_external_horn_output == o_horn)
    else $error("external horn differs from horn");
  AST_HORN_NEVER: assert property (i_horn_duration_s == `AAN_HORN_OFF && !o_horn |=> !o_horn)
    else $error("horn sounded with zero duration");
  AST_ACK_SILENCE: assert property ($rose(i_ack_command_input_fn) && i_ce && $stable(i_cause) && i_gen_input == 4'h0
    |=> ##[0:1] !o_horn)
    else $error("acknowledge input left horn on");
  AST_ACK_PULSE: assert property ($rose(i_ack_command_input_fn) && i_ce |=> ##[0:1] o_ack_pulse_output)
    else $error("acknowledge pulse missing");
  AST_RST_PULSE: assert property (($rose(i_fault_reset_input_fn) || i_key_off_reset) && i_ce
    |=> ##[0:1] o_reset_pulse_output)
    else $error("reset pulse missing");
  AST_STATUS: assert property (o_reset_pulse_status == o_reset_pulse_output)
    else $error("reset status differs from output");
  AST_BREAKER: assert property ($stable(o_active) |-> o_breaker_fault_output == (|o_active[3:0]))
    else $error("breaker output wrong");
  AST_KEEP: assert property ((o_active[7:0] & held) == held)
    else $error("anomaly cleared while cause present");
  AST_PW: assert property (i_ce && i_reg_wr && i_reg_addr == `AAN_REG_COMMAND && !pw_any && !i_key_off_reset
    && !i_password_bypass_input_fn && !i_fault_reset_input_fn && !o_reset_pulse_output |=> !o_reset_pulse_output)
    else $error("command taken without password");
  AST_NO_WARN: assert property ($stable(o_active) && o_active == 12'h000 |-> !o_any_warning_output)
    else $error("warning cumulative without anomaly");
endmodule
bind aan_annunciator aan_annunciator_props i_props (.i_clk, .i_sys_rst, .i_ce, .i_cause, .i_gen_input,
  .i_horn_duration_s, .i_ack_command_input_fn, .i_fault_reset_input_fn, .i_key_off_reset,
  .i_password_bypass_input_fn, .i_reg_wr, .i_reg_addr, .i_reg_wdata, .o_horn, .o_external_horn_output,
  .o_ack_pulse_output, .o_reset_pulse_output, .o_reset_pulse_status, .o_breaker_fault_output,
  .o_any_warning_output, .o_active);

// ---- verif/aan_annunciator_test.sv ----
// self-checking bench for the anomaly annunciator
// assumes the master model in aan_master and the bound checker
`timescale 1ns/100ps
`include "aan_consts.vh"
module aan_annunciator_test;
  typedef struct packed {logic [2:0] k; logic [1:0] cat; logic ovr; logic [4:0] exp;} aan_row_t;
  logic        i_clk, i_sys_rst, i_ce, i_ack_button, i_ack_command_input_fn, i_fault_reset_input_fn;
  logic        i_key_off_reset, i_password_bypass_input_fn, i_protection_bypass_input_fn;
  logic [7:0]  i_cause, i_override_subject, i_gen_category;
  logic [15:0] i_category, i_password_cfg;
  logic [3:0]  i_gen_input, i_gen_override_subject;
  logic [63:0] i_gen_delay_ms;
  logic [9:0]  i_horn_duration_s;
  wire         i_reg_wr, o_horn, o_ack_pulse_output, o_reset_pulse_output, o_event_valid;
  wire         o_any_warning_output, o_any_unload_output, o_any_alarm_output, o_any_alarm_or_unload_output;
  wire         o_breaker_fault_output;
  wire         o_external_horn_output, o_ack_pulse_status, o_reset_pulse_status, o_bypass_start_event;
  wire         o_unacked_warning_status, o_unacked_unload_status, o_unacked_alarm_status, o_bypass_end_event;
  wire [15:0]  i_reg_addr, i_reg_wdata;
  wire [11:0]  o_active, o_flashing;
  wire [9:0]   o_event_code;
  aan_row_t    rows [0:4];
  integer      mismatches, n_compared, cyc, i;
  aan_master m (.i_clk, .o_wr(i_reg_wr), .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
  aan_annunciator i_dut (.i_clk, .i_sys_rst, .i_ce, .i_cause, .i_category, .i_override_subject, .i_gen_input,
    .i_gen_delay_ms, .i_gen_category, .i_gen_override_subject, .i_horn_duration_s, .i_ack_button,
    .i_ack_command_input_fn, .i_fault_reset_input_fn, .i_key_off_reset, .i_password_bypass_input_fn,
    .i_protection_bypass_input_fn, .i_password_cfg, .i_reg_wr, .i_reg_addr, .i_reg_wdata, .o_horn,
    .o_external_horn_output, .o_ack_pulse_output, .o_reset_pulse_output, .o_ack_pulse_status,
    .o_reset_pulse_status, .o_any_warning_output, .o_any_unload_output, .o_any_alarm_output,
    .o_any_alarm_or_unload_output, .o_breaker_fault_output, .o_unacked_warning_status,
    .o_unacked_unload_status, .o_unacked_alarm_status, .o_active, .o_flashing, .o_event_valid,
    .o_event_code, .o_bypass_start_event, .o_bypass_end_event);
  task end_sim;
    begin
      if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task cy(input integer n);
    repeat (n) @(negedge i_clk);
  endtask
  // raise one specific anomaly and expect its logged code
  task raise(input [2:0] k);
    integer w;
    begin
      i_cause[k] = 1'b1;
      w = 0;
      while (o_event_valid !== 1'b1 && w < 4) begin
        cy(1);
        w = w + 1;
      end
      chk(o_event_valid, 1'b1);
      chk(o_event_code, k + 10'h001);
      cy(2);
    end
  endtask
  task press;
    begin
      i_ack_button = 1'b1;
      cy(2);
      i_ack_button = 1'b0;
      cy(3);
    end
  endtask
  // drop causes, acknowledge by input edge, reset by key
  task clr;
    begin
      i_cause = 8'h00;
      i_gen_input = 4'h0;
      cy(2);
      i_ack_command_input_fn = 1'b1;
      cy(2);
      i_ack_command_input_fn = 1'b0;
      i_key_off_reset = 1'b1;
      cy(2);
      i_key_off_reset = 1'b0;
      cy(2);
    end
  endtask
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      end_sim;
    end
  end
  initial begin
    {mismatches, n_compared, cyc} = 0;
    {i_ack_button, i_ack_command_input_fn, i_fault_reset_input_fn, i_key_off_reset} = 4'h0;
    {i_password_bypass_input_fn, i_protection_bypass_input_fn, i_cause, i_override_subject} = 18'h00000;
    {i_category, i_gen_input, i_gen_delay_ms, i_gen_category, i_gen_override_subject} = 96'h0;
    i_password_cfg = 16'h2468;
    i_horn_duration_s = `AAN_HORN_OFF;
    i_ce = 1'b1;
    i_sys_rst = 1'b1;
    rows[0] = '{3'h0, `AAN_CAT_WARN, 1'b0, 5'h11};
    rows[1] = '{3'h4, `AAN_CAT_UNLOAD, 1'b0, 5'h0A};
    rows[2] = '{3'h5, `AAN_CAT_ALARM, 1'b0, 5'h06};
    rows[3] = '{3'h6, `AAN_CAT_ALARM, 1'b1, 5'h10};
    rows[4] = '{3'h2, `AAN_CAT_ALARM, 1'b0, 5'h07};
    cy(20);
    i_sys_rst = 1'b0;
    chk(o_active, 12'h000);
    m.wr(`AAN_REG_COMMAND, `AAN_CMD_RESET);
    m.cmd(16'h1111, `AAN_CMD_RESET);
    cy(2);
    chk(o_reset_pulse_output, 1'b0);
    raise(3'h1);
    chk(o_horn, 1'b0);
    clr;
    i_horn_duration_s = `AAN_HORN_FOREVER;
    for (i = 0; i < 5; i = i + 1) begin
      i_category[2*rows[i].k +: 2] = rows[i].cat;
      i_override_subject[rows[i].k] = rows[i].ovr;
      i_protection_bypass_input_fn = rows[i].ovr;
      cy(2);
      raise(rows[i].k);
      chk({o_any_warning_output, o_any_unload_output, o_any_alarm_output, o_any_alarm_or_unload_output,
           o_breaker_fault_output}, rows[i].exp);
      chk({o_unacked_warning_status, o_unacked_unload_status, o_unacked_alarm_status}, rows[i].exp[4:2]);
      chk(o_horn, 1'b1);
      chk(o_external_horn_output, 1'b1);
      clr;
      chk(o_active, 12'h000);
      chk({o_ack_pulse_output, o_ack_pulse_status, o_reset_pulse_output, o_reset_pulse_status}, 4'hF);
    end
    raise(3'h1);
    i_cause[1] = 1'b0;
    press;
    chk(o_horn, 1'b0);
    chk(o_active[1] & o_flashing[1], 1'b1);
    chk(o_unacked_warning_status, 1'b1);
    press;
    chk(o_flashing[1], 1'b0);
    chk(o_active[1], 1'b0);
    i_category[7:6] = `AAN_CAT_ALARM;
    raise(3'h3);
    i_cause[0] = 1'b1;
    cy(3);
    chk(o_active[0], 1'b0);
    m.cmd(i_password_cfg, 16'h0036);
    cy(3);
    chk(o_horn, 1'b1);
    m.cmd(i_password_cfg, `AAN_CMD_SILENCE);
    cy(3);
    chk({o_horn, o_flashing[3]}, 2'h1);
    clr;
    raise(3'h3);
    m.cmd(i_password_cfg, `AAN_CMD_ACK);
    cy(3);
    chk({o_horn, o_flashing[3]}, 2'h0);
    i_fault_reset_input_fn = 1'b1;
    cy(3);
    chk(o_active[3], 1'b1);
    i_fault_reset_input_fn = 1'b0;
    i_cause[3] = 1'b0;
    m.cmd(i_password_cfg, `AAN_CMD_RESET);
    cy(3);
    chk(o_active[3], 1'b0);
    i_gen_input = 4'h1;
    cy(5);
    chk(o_active[8], 1'b0);
    clr;
    i_horn_duration_s = 10'h001;
    raise(3'h1);
    cy(50);
    chk(o_horn, 1'b1);
    i_protection_bypass_input_fn = 1'b1;
    cy(1);
    chk(o_bypass_start_event, 1'b1);
    i_protection_bypass_input_fn = 1'b0;
    cy(1);
    chk(o_bypass_end_event, 1'b1);
    clr;
    end_sim;
  end
endmodule
